// >>> tb/cscr_regs_props.sv
// cscr_regs_props: port-level assertions on the control byte block.
// assumes binding into cscr_regs; one clock, async active-high reset.
`timescale 1ns/1ps
module cscr_regs_props
(
    input wire logic       core_clk_in,              // clock
    input wire logic       rst_in,                   // reset
    input wire logic [7:0] cfg_addr_in,              // offset
    input wire logic       cfg_wr_in,                // write strobe
    input wire logic       cfg_byte_en_in,           // byte enable
    input wire logic [7:0] cfg_wdata_in,             // write data
    input wire logic [7:0] cfg_rdata_out,            // read data
    input wire logic       ring_in,                  // ring pin
    input wire logic       card_speaker_in,          // speaker pin
    input wire logic       pwr_off_req_in,           // power-off request
    input wire logic       ring_indicate_output_out, // ring out
    input wire logic       video_port_oe_out,        // video enable
    input wire logic       card_audio_routed_out,    // audio route
    input wire logic       host_speaker_out_out,     // speaker out
    input wire logic       socket_power_on_out,      // socket power
    input wire logic       low_volt_capable_out,     // 3 v report
    input wire logic [1:0] irq_signal_mode_out,      // irq mode
    input wire logic       interrog_tick_out         // interval tick
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    // accepted writes per byte; gated by the enable so a stray strobe is no write
    wire w91 = cfg_wr_in && cfg_byte_en_in && cfg_addr_in == 8'h91;
    wire w92 = cfg_wr_in && cfg_byte_en_in && cfg_addr_in == 8'h92;
    // written bits reach the steering outputs one edge later
    AST_VIDEO_TRI: assert property (w91 |=> video_port_oe_out == !$past(cfg_wdata_in[6]))
        else $error("video enable does not follow written bit");
    AST_AUDIO_ROUTE: assert property (w91 |=> card_audio_routed_out == !$past(cfg_wdata_in[2]))
        else $error("audio route does not follow written bit");
    AST_LOW_VOLT: assert property (w92 |=> low_volt_capable_out == $past(cfg_wdata_in[6]))
        else $error("low volt report does not follow written bit");
    AST_IRQ_MODE: assert property (w92 |=> irq_signal_mode_out == $past(cfg_wdata_in[2:1]))
        else $error("irq mode does not follow written bits");
    AST_RSVD_ZERO: assert property ((cfg_addr_in == 8'h91 |=> cfg_rdata_out[5:3] == 3'h0) and (cfg_addr_in == 8'h92 |=> !cfg_rdata_out[4]))
        else $error("reserved bits read nonzero");
    AST_BYTE_EN: assert property (cfg_wr_in && !cfg_byte_en_in |=> $stable(video_port_oe_out) && $stable(low_volt_capable_out))
        else $error("write without byte enable changed a register");
    // pin paths run through a three-edge pipe
    AST_RING_PATH: assert property (ring_indicate_output_out |-> $past(ring_in, 3))
        else $error("ring out high without ring pin");
    AST_CARD_SPEAKER_IN_PATH: assert property (host_speaker_out_out |-> $past(card_speaker_in, 3))
        else $error("speaker out high without speaker pin");
    AST_PWR_KEEP: assert property (!pwr_off_req_in |=> socket_power_on_out)
        else $error("power off without request");
    AST_TICK_PULSE: assert property (interrog_tick_out |=> !interrog_tick_out)
        else $error("interval tick longer than one cycle");
    COV_W91: cover property (w91 ##1 w92);
    COV_PWR_OFF: cover property (pwr_off_req_in ##1 !socket_power_on_out);
    COV_TICK: cover property (interrog_tick_out);
endmodule : cscr_regs_props

bind cscr_regs cscr_regs_props cscr_regs_props_inst (.core_clk_in, .rst_in, .cfg_addr_in,
    .cfg_wr_in, .cfg_byte_en_in, .cfg_wdata_in, .cfg_rdata_out, .ring_in, .card_speaker_in,
    .pwr_off_req_in, .ring_indicate_output_out, .video_port_oe_out, .card_audio_routed_out,
    .host_speaker_out_out, .socket_power_on_out, .low_volt_capable_out, .irq_signal_mode_out,
    .interrog_tick_out);

// >>> tb/cscr_socket_model.sv
// cscr_socket_model: card socket lines as the bridge sees them.
// assumes the bench calls its tasks; all lines move on the falling edge.
`timescale 1ns/1ps
module cscr_socket_model
(
    input  wire logic core_clk_in, // clock
    output logic      irq_out,     // functional interrupt
    output logic      cb_out,      // card is cardbus
    output logic      io_out,      // card is 16-bit io
    output logic [2:0] lines_out,  // ring, audio, speaker
    output logic [7:0] pins_out    // nand tree pins
);
    initial {irq_out, cb_out, io_out, lines_out, pins_out} = 14'h0000;
    // pins change every cycle so a stale sample cannot match by luck
    always @(negedge core_clk_in) pins_out <= 8'($urandom);
    // card type is set on the same edge as the interrupt and then stands as a level
    task automatic fire(input logic cb, input logic io);
        @(negedge core_clk_in);
        {cb_out, io_out, irq_out} = {cb, io, 1'b1};
        repeat (3) @(negedge core_clk_in);
        irq_out = 1'b0;
    endtask : fire
    task automatic drive(input logic [2:0] v);
        @(negedge core_clk_in);
        lines_out = v;
    endtask : drive
endmodule : cscr_socket_model

// >>> tb/tb_cscr_regs.sv
// tb_cscr_regs: random and corner traffic on the control byte block.
// assumes the checker is bound in and the socket model drives the pins.
`timescale 1ns/1ps
module tb_cscr_regs;
    logic       clk, rst, wr_s, be, d3, preq, irq, io, cb, ring_o, vid, aud_p, aud_r;
    logic       spk_o, pwr, lv, nand_o, tick;
    logic [1:0] mode;
    logic [2:0] lines;
    logic [7:0] addr, wdata, rdata, cc, dc, pins, a, d, ph1, ph2, ph3;
    int         num_errors, checks, cyc, n;
    cscr_socket_model cscr_socket_model_inst (.core_clk_in(clk), .irq_out(irq), .cb_out(cb),
        .io_out(io), .lines_out(lines), .pins_out(pins));
    cscr_regs cscr_regs_inst
    (
        .core_clk_in(clk), .rst_in(rst), .cfg_addr_in(addr), .cfg_wr_in(wr_s),
        .cfg_byte_en_in(be), .cfg_wdata_in(wdata), .cfg_rdata_out(rdata), .card_irq_in(irq),
        .card_is_16bit_io_in(io), .card_is_cardbus_in(cb), .ring_in(lines[2]),
        .card_audio_signal_in(lines[1]), .card_speaker_in(lines[0]), .nand_pins_in(pins),
        .func_in_d3_in(d3), .pwr_off_req_in(preq), .ring_indicate_output_out(ring_o),
        .video_port_oe_out(vid), .card_audio_pulse_out_out(aud_p), .card_audio_routed_out(aud_r),
        .host_speaker_out_out(spk_o), .socket_power_on_out(pwr), .low_volt_capable_out(lv),
        .irq_signal_mode_out(mode), .nand_tree_out(nand_o), .interrog_tick_out(tick)
    );
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // hang guard; sits above the 70000-cycle bound of the interval wait loop, which the test bit ends within about 16 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            num_errors++;
            print_verdict();
        end
    end
    // pin history; the chain output reflects pins seen three edges back
    always @(posedge clk)
    begin
        ph1 <= pins;
        ph2 <= ph1;
        ph3 <= ph2;
    end
    // expected chain result over the eight modelled pins
    function automatic logic nand_chain(input logic [7:0] p);
        logic r;
        r = 1'b1;
        for (int i = 0; i < 8; i++)
            r = ~(r & p[i]);
        return r;
    endfunction : nand_chain
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    // bench copy of a byte after an accepted write
    function automatic logic [7:0] after_wr(input logic [7:0] ofs, v, old);
        if (ofs == 8'h91)
            return {v[7:6], 3'h0, v[2:1], old[0] & !v[0]};
        return v & 8'hEF;
    endfunction : after_wr
    task automatic do_reset();
        rst = 1'b1;
        repeat (3) @(negedge clk);
        {rst, cc, dc} = {1'b0, 8'h00, 8'h66};
    endtask : do_reset
    task automatic wr(input logic [7:0] ofs, input logic [7:0] v, input logic e);
        @(negedge clk);
        {addr, wdata, wr_s, be} = {ofs, v, 1'b1, e};
        @(negedge clk);
        wr_s = 1'b0;
        if (e && ofs == 8'h91)
            cc = after_wr(ofs, v, cc);
        if (e && ofs == 8'h92)
            dc = after_wr(ofs, v, dc);
    endtask : wr
    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp, input string what);
        @(negedge clk);
        addr = ofs;
        @(negedge clk);
        chk(what, exp, rdata);
    endtask : rd
    task automatic chk_outs();
        chk("video oe", 8'(!cc[6]), 8'(vid));
        chk("audio route", 8'(!cc[2]), 8'(aud_r));
        chk("low volt", 8'(dc[6]), 8'(lv));
        chk("irq mode", 8'(dc[2:1]), 8'(mode));
    endtask : chk_outs
    initial
    begin
        void'($urandom(20));
        {addr, wdata, wr_s, be, d3, preq} = 20'h00000;
        do_reset();
        rd(8'h91, 8'h00, "cc reset");
        rd(8'h92, 8'h66, "dc reset");
        chk_outs();
        chk("power reset", 8'h01, 8'(pwr));
        // corner writes then random traffic; bit 3 kept clear as software must
        wr(8'h91, 8'hFF, 1'b1);
        rd(8'h91, cc, "cc all ones");
        repeat (40)
        begin
            a = 8'h91 + 8'($urandom % 3);
            d = 8'($urandom) & 8'hF7;
            wr(a, d, 1'($urandom));
            chk_outs();
            rd(a, a == 8'h91 ? cc : a == 8'h92 ? dc : 8'h00, "readback");
        end
        for (int m = 0; m < 4; m++)
        begin
            wr(8'h92, 8'h60 | 8'(m << 1), 1'b1);
            chk_outs();
        end
        repeat (4) @(negedge clk);
        chk("nand off", 8'h00, 8'(nand_o));
        wr(8'h92, 8'h61, 1'b1);
        repeat (4) @(negedge clk);
        repeat (8)
        begin
            @(negedge clk);
            chk("nand on", 8'(nand_chain(ph3)), 8'(nand_o));
        end
        wr(8'h92, 8'h66, 1'b1);
        // no card type, cardbus, 16-bit io, both: flag then zero and one writes
        wr(8'h91, 8'h01, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            cscr_socket_model_inst.fire(k[0], k[1]);
            cc[0] = cc[0] | (k != 0);
            repeat (6) @(negedge clk);
            rd(8'h91, cc, "irq flag");
            wr(8'h91, 8'h00, 1'b1);
            rd(8'h91, cc, "flag kept");
            wr(8'h91, 8'h01, 1'b1);
            rd(8'h91, cc, "flag cleared");
        end
        // socket pin paths enabled, then disabled
        wr(8'h91, 8'h82, 1'b1);
        cscr_socket_model_inst.drive(3'b111);
        repeat (4) @(negedge clk);
        chk("ring", 8'h01, 8'(ring_o));
        chk("speaker", 8'h01, 8'(spk_o));
        chk("audio", 8'h01, 8'(aud_p));
        wr(8'h91, 8'h44, 1'b1);
        repeat (4) @(negedge clk);
        chk("ring off", 8'h00, 8'(ring_o));
        chk("speaker off", 8'h00, 8'(spk_o));
        chk("audio off", 8'h00, 8'(aud_p));
        chk_outs();
        // power hold in d3, then released by leaving d3
        wr(8'h92, 8'hE6, 1'b1);
        d3 = 1'b1;
        repeat (4) @(negedge clk);
        preq = 1'b1;
        repeat (2) @(negedge clk);
        chk("power held", 8'h01, 8'(pwr));
        d3 = 1'b0;
        repeat (4) @(negedge clk);
        chk("power off", 8'h00, 8'(pwr));
        preq = 1'b0;
        repeat (2) @(negedge clk);
        chk("power back", 8'h01, 8'(pwr));
        // test bit shortens the interval to sixteen cycles
        wr(8'h92, 8'h6E, 1'b1);
        for (int i = 0; i < 70000 && tick !== 1'b1; i++)
            @(negedge clk);
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end while (tick !== 1'b1 && n < 100);
        chk("interval", 8'h10, 8'(n));
        do_reset();
        rd(8'h92, 8'h66, "dc second reset");
        print_verdict();
    end
endmodule : tb_cscr_regs

// >>> verilog/cscr_interrog.sv
// cscr_interrog: card interrogation interval counter; emits a one-cycle
// tick each time the interval ends, shortened when the test bit is set.
// assumes one clock; interval reloads at each tick.
`timescale 1ns/1ps
module cscr_interrog
(
    input  wire logic core_clk_in,   // 50 mhz clock
    input  wire logic rst_in,        // async reset, high
    input  wire logic short_in,      // test bit: use short interval
    output logic      tick_out       // interval end pulse
);
    import cscr_pkg::*;

    typedef struct packed
    {
        logic [15:0] cnt;
        logic        tick;
    } cscr_cnt_state_type;

    cscr_cnt_state_type st_r;
    cscr_cnt_state_type st_nxt;

    // counting down lets a longer length take hold at the next reload; setting the test bit cuts a longer wait at once
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.cnt == 16'h0000)
        begin
            st_nxt.tick = 1'b1;
            st_nxt.cnt  = short_in ? CSCR_INTERROG_SHORT : CSCR_INTERROG_LONG;
        end
        else if (short_in && (st_r.cnt > CSCR_INTERROG_SHORT))
        begin
            st_nxt.cnt = CSCR_INTERROG_SHORT;  // cut a long wait at once
        end
        else
        begin
            st_nxt.cnt = st_r.cnt - 16'h0001;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign tick_out = st_r.tick;
endmodule : cscr_interrog

// >>> verilog/cscr_irq_flag.sv
// cscr_irq_flag: sticky card functional interrupt flag, write one to clear.
// assumes the event input is already on core_clk_in.
`timescale 1ns/1ps
module cscr_irq_flag
(
    input  wire logic core_clk_in,   // 50 mhz clock
    input  wire logic rst_in,        // async reset, high
    input  wire logic set_in,        // functional interrupt event
    input  wire logic clr_in,        // write of one to the flag
    output logic      flag_out       // sticky flag
);
    import cscr_pkg::*;

    typedef struct packed
    {
        logic flag;
    } cscr_flag_state_type;

    cscr_flag_state_type st_r;
    cscr_flag_state_type st_nxt;

    // set wins over a clear in the same cycle so no event is lost
    always_comb
    begin
        st_nxt = st_r;
        if (clr_in)
        begin
            st_nxt.flag = 1'b0;
        end
        if (set_in)
        begin
            st_nxt.flag = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign flag_out = st_r.flag;
endmodule : cscr_irq_flag

// >>> verilog/cscr_pkg.sv
// cscr_pkg: offsets, bit positions, reset values and modes shared by the
// card/device control register block and its helpers.
// assumes byte-wide configuration access with one enable per byte lane.
package cscr_pkg;
    // config byte offsets of the two registers
    localparam logic [7:0] CSCR_CARD_CTRL_OFS = 8'h91;
    localparam logic [7:0] CSCR_DEV_CTRL_OFS  = 8'h92;

    // card control bit positions
    localparam int CSCR_CC_RING_BIT  = 7;
    localparam int CSCR_CC_VIDEO_BIT = 6;
    localparam int CSCR_CC_AUDIO_BIT = 2;
    localparam int CSCR_CC_CARD_SPEAKER_IN_BIT  = 1;
    localparam int CSCR_CC_IRQ_BIT   = 0;

    // device control bit positions
    localparam int CSCR_DC_PWRHOLD_BIT = 7;
    localparam int CSCR_DC_LOWVOLT_BIT = 6;
    localparam int CSCR_DC_DIAG5_BIT   = 5;
    localparam int CSCR_DC_TEST_BIT    = 3;
    localparam int CSCR_DC_MODE_HI     = 2;
    localparam int CSCR_DC_MODE_LO     = 1;
    localparam int CSCR_DC_NAND_BIT    = 0;

    // writable bit masks; zeros mark bits that writes do not load, which read as zero except the card control interrupt flag
    localparam logic [7:0] CSCR_CC_WMASK = 8'hC6;
    localparam logic [7:0] CSCR_DC_WMASK = 8'hEF;

    // reset values
    localparam logic [7:0] CSCR_CC_RESET = 8'h00;
    localparam logic [7:0] CSCR_DC_RESET = 8'h66;

    // interrogation counter lengths, normal and shortened by the test bit
    localparam logic [15:0] CSCR_INTERROG_LONG  = 16'hFFFF;
    localparam logic [15:0] CSCR_INTERROG_SHORT = 16'h000F;

    // interrupt signalling modes
    typedef enum logic [1:0] {
        CSCR_IRQ_PAR_PCI   = 2'b00,
        CSCR_IRQ_PAR_BOTH  = 2'b01,
        CSCR_IRQ_SER_ISA   = 2'b10,
        CSCR_IRQ_SER_ALL   = 2'b11
    } cscr_irq_mode_type;
endpackage : cscr_pkg

// >>> verilog/cscr_regs.sv
// cscr_regs: card control and device control configuration bytes of the
// card socket bridge, with the socket-side controls they steer.
// assumes a byte-addressed config port on core_clk_in with a per-cycle
// write strobe and byte enable; socket pins arrive asynchronously.
// Notes on behaviour
// - Card control bit 7 enables the ring indicate output and resets to zero.
// - Card control bit 6 set puts the zoomed video terminals in high impedance; resets zero.
// - Card control bits 5 to 3 are read-only zero.
// - Card control bit 2 zero routes card audio as a pulse on a multipurpose pin, one leaves it unrouted.
// - Card control bit 1 passes the card speaker signal to the host speaker output.
// - Card control bit 0 is set by a functional interrupt from a 16-bit io or cardbus card; reset zero.
// - Writing one to the card interrupt flag clears it; writing zero leaves it.
// - Device control bit 7 set refuses removal of socket power while in d3.
// - Device control bit 6 forces the 3 volt capable indication, default one.
// - Device control bit 5 is a read-write diagnostic bit resetting to one.
// - Device control bit 4 reads zero and ignores writes.
// - Device control bit 3 is a test bit that shortens the interrogation counter; software writes zero.
// - Device control bits 2 to 1 select the interrupt signalling mode, default fully serial.
// - Device control bit 0 enables a nand-tree chain over input and two-way pins only.
`timescale 1ns/1ps
module cscr_regs
(
    input  wire logic        core_clk_in,          // 50 mhz bus clock
    input  wire logic        rst_in,               // async reset, high
    // configuration access
    input  wire logic [7:0]  cfg_addr_in,          // byte offset
    input  wire logic        cfg_wr_in,            // write strobe
    input  wire logic        cfg_byte_en_in,       // byte enable for this byte
    input  wire logic [7:0]  cfg_wdata_in,         // write data
    output logic [7:0]       cfg_rdata_out,        // read data
    // socket inputs (asynchronous)
    input  wire logic        card_irq_in,          // card functional interrupt
    input  wire logic        card_is_16bit_io_in,  // card is a 16-bit io card
    input  wire logic        card_is_cardbus_in,   // card is a cardbus card
    input  wire logic        ring_in,              // ring from card
    input  wire logic        card_audio_signal_in, // card audio
    input  wire logic        card_speaker_in,      // card speaker
    input  wire logic [7:0]  nand_pins_in,         // input and two-way pins
    // power management
    input  wire logic        func_in_d3_in,        // function in d3
    input  wire logic        pwr_off_req_in,       // software asks power off
    // outputs
    output logic             ring_indicate_output_out, // ring indicate
    output logic             video_port_oe_out,    // zoomed video drive enable
    output logic             card_audio_pulse_out_out, // audio on multipurpose pin
    output logic             card_audio_routed_out,    // audio route active
    output logic             host_speaker_out_out, // host speaker
    output logic             socket_power_on_out,  // socket power enable
    output logic             low_volt_capable_out, // 3 v capable report
    output logic [1:0]       irq_signal_mode_out,  // interrupt signalling mode
    output logic             nand_tree_out,        // nand tree result
    output logic             interrog_tick_out     // interrogation interval tick
);
    import cscr_pkg::*;

    // two-stage synchronisers, one per pin bit after the two card type pins are ored
    localparam int SYNC_W = 14;

    typedef struct packed
    {
        logic [7:0]        card_ctrl;
        logic [7:0]        dev_ctrl;
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        logic              irq_prev;
        logic              pwr_on;
        logic [7:0]        rdata;
        logic              ring_q;
        logic              audio_q;
        logic              card_speaker_in_q;
        logic              nand_q;
    } cscr_state_type;

    cscr_state_type st_r;
    cscr_state_type st_nxt;

    logic [SYNC_W-1:0] pins_raw;
    logic [7:0]        nand_s;
    logic              irq_s;
    logic              irq_event;
    logic              wr_cc;
    logic              wr_dc;
    logic              flag_clr;
    logic              flag_q;
    logic              nand_res;

    assign pins_raw = {nand_pins_in, func_in_d3_in, card_irq_in, ring_in,
                       card_audio_signal_in, card_speaker_in,
                       card_is_16bit_io_in | card_is_cardbus_in};
    assign nand_s   = st_r.sync2[13:6];
    assign irq_s    = st_r.sync2[4];

    // an interrupt counts only from a 16-bit io or cardbus card
    assign irq_event = irq_s & ~st_r.irq_prev & st_r.sync2[0];

    // byte enable gates each write
    assign wr_cc    = cfg_wr_in & cfg_byte_en_in & (cfg_addr_in == CSCR_CARD_CTRL_OFS);
    assign wr_dc    = cfg_wr_in & cfg_byte_en_in & (cfg_addr_in == CSCR_DEV_CTRL_OFS);
    assign flag_clr = wr_cc & cfg_wdata_in[CSCR_CC_IRQ_BIT];

    cscr_irq_flag u_flag
    (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .set_in      (irq_event),
        .clr_in      (flag_clr),
        .flag_out    (flag_q)
    );

    cscr_interrog u_interrog
    (
        .core_clk_in (core_clk_in),
        .rst_in      (rst_in),
        .short_in    (st_r.dev_ctrl[CSCR_DC_TEST_BIT]),
        .tick_out    (interrog_tick_out)
    );

    // nand chain over the synchronised input and two-way pins only;
    // outputs are left out because they would only echo this logic
    always_comb
    begin
        nand_res = 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            nand_res = ~(nand_res & nand_s[i]);
        end
    end

    // register writes, socket control and read data
    always_comb
    begin
        st_nxt          = st_r;
        st_nxt.sync1    = pins_raw;
        st_nxt.sync2    = st_r.sync1;
        st_nxt.irq_prev = irq_s;
        // read-only bits masked off so they stay zero
        if (wr_cc)
        begin
            st_nxt.card_ctrl = cfg_wdata_in & CSCR_CC_WMASK;
        end
        if (wr_dc)
        begin
            st_nxt.dev_ctrl = cfg_wdata_in & CSCR_DC_WMASK;
        end
        // power stays on while the hold bit is set and the function is in d3
        if (pwr_off_req_in)
        begin
            if (!(st_r.dev_ctrl[CSCR_DC_PWRHOLD_BIT] && st_r.sync2[5]))
            begin
                st_nxt.pwr_on = 1'b0;
            end
        end
        else
        begin
            st_nxt.pwr_on = 1'b1;
        end
        st_nxt.ring_q  = st_r.card_ctrl[CSCR_CC_RING_BIT] & st_r.sync2[3];
        st_nxt.audio_q = ~st_r.card_ctrl[CSCR_CC_AUDIO_BIT] & st_r.sync2[2];
        st_nxt.card_speaker_in_q  = st_r.card_ctrl[CSCR_CC_CARD_SPEAKER_IN_BIT] & st_r.sync2[1];
        st_nxt.nand_q  = st_r.dev_ctrl[CSCR_DC_NAND_BIT] ? nand_res : 1'b0;
        // read data is registered; unmapped offsets read zero
        unique case (cfg_addr_in)
            CSCR_CARD_CTRL_OFS:
                st_nxt.rdata = {st_r.card_ctrl[7:1], flag_q};
            CSCR_DEV_CTRL_OFS:
                st_nxt.rdata = st_r.dev_ctrl;
            default:
                st_nxt.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_r           <= '0;
            st_r.card_ctrl <= CSCR_CC_RESET;
            st_r.dev_ctrl  <= CSCR_DC_RESET;
            st_r.pwr_on    <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // socket-facing outputs
    assign ring_indicate_output_out = st_r.ring_q;
    assign video_port_oe_out        = ~st_r.card_ctrl[CSCR_CC_VIDEO_BIT];
    assign card_audio_pulse_out_out = st_r.audio_q;
    assign card_audio_routed_out    = ~st_r.card_ctrl[CSCR_CC_AUDIO_BIT];
    assign host_speaker_out_out     = st_r.card_speaker_in_q;
    assign socket_power_on_out      = st_r.pwr_on;
    assign low_volt_capable_out     = st_r.dev_ctrl[CSCR_DC_LOWVOLT_BIT];
    assign irq_signal_mode_out      = st_r.dev_ctrl[CSCR_DC_MODE_HI:CSCR_DC_MODE_LO];
    assign nand_tree_out            = st_r.nand_q;
    assign cfg_rdata_out            = st_r.rdata;
endmodule : cscr_regs
